// *** src/dlg_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dlg_params.svh"
module dlg_top
    import dlg_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic [`DLG_ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic rx_start_in,
    input wire logic carrier_sense_in,
    input wire logic sync_detect_in,
    output logic freq_loop_freeze_out,
    output logic clkrec_loop_freeze_out,
    output logic post_sync_out,
    output logic [3:0] freq_gain_out,
    output logic [3:0] clkrec_integral_gain_out,
    output logic [3:0] clkrec_proportional_gain_out,
    output logic [1:0] freq_offset_saturation_out,
    output logic freq_comp_enable_out,
    output logic [1:0] clkrec_rate_saturation_out
);
    // stored configuration registers
    logic [7:0] foc_q;
    logic [7:0] foc_d;
    logic [7:0] bs_q;
    logic [7:0] bs_d;
    // read data, holds until the next taken read
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    // receive attempt tracking
    dlg_phase_t phase_q;
    dlg_phase_t phase_d;
    logic carrier_seen_q;
    logic carrier_seen_d;
    // decoded register port strobes
    logic wr_foc;
    logic wr_bs;
    logic rd_take;
    // field views of the stored registers
    logic loops_gate_on_carrier;
    dlg_code_t freq_gain_presync;
    logic freq_gain_postsync;
    dlg_code_t freq_offset_saturation;
    dlg_code_t clkrec_integral_presync;
    logic clkrec_integral_postsync;
    dlg_code_t clkrec_proportional_presync;
    logic clkrec_proportional_postsync;
    dlg_code_t clkrec_rate_saturation;
    // live loop control
    logic post_now;
    logic freeze_now;

    dlg_gain_if gif ();

    // port decode; the clock enable gates every strobe
    assign wr_foc = clk_en_in && reg_wr_in && (reg_addr_in == `DLG_ADDR_FOC);
    assign wr_bs = clk_en_in && reg_wr_in && (reg_addr_in == `DLG_ADDR_BS);
    assign rd_take = clk_en_in && reg_rd_in;

    // register writes; unused frequency bits never reach the flops
    // so a read-back of them is always zero
    always_comb begin
        foc_d = foc_q;
        bs_d = bs_q;
        if (wr_foc) begin
            foc_d = reg_wdata_in & `DLG_FOC_USED_MASK;
        end
        if (wr_bs) begin
            bs_d = reg_wdata_in;
        end
    end

    // registers come up at their defaults, gate bit set
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            foc_q <= `DLG_FOC_RESET;
            bs_q <= `DLG_BS_RESET;
        end else if (clk_en_in) begin
            foc_q <= foc_d;
            bs_q <= bs_d;
        end
    end

    // read mux samples the old value, so a write to the
    // same address in the same cycle is not seen yet
    always_comb begin
        rdata_d = rdata_q;
        if (rd_take) begin
            unique case (reg_addr_in)
                `DLG_ADDR_FOC: rdata_d = foc_q;
                `DLG_ADDR_BS: rdata_d = bs_q;
                default: rdata_d = `DLG_RDATA_NONE; // unmapped reads zero
            endcase
        end
    end

    // read data register
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= `DLG_RDATA_NONE;
        end else if (clk_en_in) begin
            rdata_q <= rdata_d;
        end
    end

    // receive phase; a start always reopens presync, and a
    // sync pulse only counts while presync is open
    always_comb begin
        phase_d = phase_q;
        if (rx_start_in) begin
            phase_d = DLG_PRESYNC;
        end else begin
            unique case (phase_q)
                DLG_IDLE: phase_d = DLG_IDLE;
                DLG_PRESYNC: begin
                    if (sync_detect_in) begin
                        phase_d = DLG_POSTSYNC;
                    end
                end
                DLG_POSTSYNC: phase_d = DLG_POSTSYNC;
                default: phase_d = DLG_IDLE; // unused code falls back to idle
            endcase
        end
    end

    // phase register
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q <= DLG_IDLE;
        end else if (clk_en_in) begin
            phase_q <= phase_d;
        end
    end

    // carrier-seen flag, sticky for the rest of an attempt;
    // a start reloads it from the live carrier so a carrier
    // already present at the start is not missed
    always_comb begin
        carrier_seen_d = carrier_seen_q;
        if (rx_start_in) begin
            carrier_seen_d = carrier_sense_in;
        end else if (carrier_sense_in) begin
            carrier_seen_d = 1'b1;
        end
    end

    // carrier-seen register
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            carrier_seen_q <= 1'b0;
        end else if (clk_en_in) begin
            carrier_seen_q <= carrier_seen_d;
        end
    end

    // frequency compensation register fields
    assign loops_gate_on_carrier = foc_q[`DLG_FOC_GATE_BIT];
    assign freq_gain_presync = foc_q[`DLG_FOC_PRE_HI:`DLG_FOC_PRE_LO];
    assign freq_gain_postsync = foc_q[`DLG_FOC_POST_BIT];
    assign freq_offset_saturation = foc_q[`DLG_FOC_LIM_HI:`DLG_FOC_LIM_LO];

    // bit synchronisation register fields
    assign clkrec_integral_presync = bs_q[`DLG_BS_KI_HI:`DLG_BS_KI_LO];
    assign clkrec_integral_postsync = bs_q[`DLG_BS_POST_KI_BIT];
    assign clkrec_proportional_presync = bs_q[`DLG_BS_KP_HI:`DLG_BS_KP_LO];
    assign clkrec_proportional_postsync = bs_q[`DLG_BS_POST_KP_BIT];
    assign clkrec_rate_saturation = bs_q[`DLG_BS_LIM_HI:`DLG_BS_LIM_LO];

    // postsync takes effect in the very cycle sync is flagged;
    // kept combinational so no gain lags the sync pulse, and
    // a start in the same cycle wins over a late sync
    assign post_now = !rx_start_in && ((phase_q == DLG_POSTSYNC)
                      || (phase_q == DLG_PRESYNC && sync_detect_in));
    assign post_sync_out = post_now;

    // loops held until carrier sense has been high this attempt;
    // the live carrier releases them without waiting a cycle
    assign freeze_now = loops_gate_on_carrier && !carrier_seen_q
                        && !carrier_sense_in;
    assign freq_loop_freeze_out = freeze_now;
    assign clkrec_loop_freeze_out = freeze_now;

    // gain selection bundle towards the selector
    assign gif.foc_pre = freq_gain_presync;
    assign gif.foc_post = freq_gain_postsync;
    assign gif.ki_pre = clkrec_integral_presync;
    assign gif.ki_post = clkrec_integral_postsync;
    assign gif.kp_pre = clkrec_proportional_presync;
    assign gif.kp_post = clkrec_proportional_postsync;
    assign gif.post_active = post_now;

    // per-loop gain selection, pre or post by phase
    dlg_gain_sel u_gain_sel (
        .g(gif.sel)
    );

    // selected gains, in half-units of each base gain
    assign freq_gain_out = gif.foc_gain;
    assign clkrec_integral_gain_out = gif.ki_gain;
    assign clkrec_proportional_gain_out = gif.kp_gain;

    // saturation limits; code zero switches compensation off,
    // which host software must choose for amplitude keying
    assign freq_offset_saturation_out = freq_offset_saturation;
    assign freq_comp_enable_out = |freq_offset_saturation;
    assign clkrec_rate_saturation_out = clkrec_rate_saturation;

    // read data straight from its register
    assign reg_rdata_out = rdata_q;
endmodule
`default_nettype wire

// *** src/dlg_params.svh ***
`ifndef DLG_PARAMS_SVH
`define DLG_PARAMS_SVH

// register addresses on the internal configuration port
`define DLG_ADDR_W 6
`define DLG_ADDR_FOC 6'h19
`define DLG_ADDR_BS 6'h1a
// read data after reset and for an unmapped address
`define DLG_RDATA_NONE 8'h00

// frequency offset compensation register fields
`define DLG_FOC_GATE_BIT 5
`define DLG_FOC_PRE_HI 4
`define DLG_FOC_PRE_LO 3
`define DLG_FOC_POST_BIT 2
`define DLG_FOC_LIM_HI 1
`define DLG_FOC_LIM_LO 0
`define DLG_FOC_USED_MASK 8'h3f
`define DLG_FOC_RESET 8'h36

// bit synchronisation register fields
`define DLG_BS_KI_HI 7
`define DLG_BS_KI_LO 6
`define DLG_BS_KP_HI 5
`define DLG_BS_KP_LO 4
`define DLG_BS_POST_KI_BIT 3
`define DLG_BS_POST_KP_BIT 2
`define DLG_BS_LIM_HI 1
`define DLG_BS_LIM_LO 0
`define DLG_BS_RESET 8'h6c

// gains are expressed in half-units of the base gain
`define DLG_GAIN_HALF 4'h1
`define DLG_GAIN_ONE 4'h2

`endif

// *** src/dlg_pkg.sv ***
package dlg_pkg;
    // receive phase, gray coded along idle -> presync -> postsync
    typedef enum logic [1:0] {
        DLG_IDLE = 2'b00,
        DLG_PRESYNC = 2'b01,
        DLG_POSTSYNC = 2'b11
    } dlg_phase_t;

    typedef logic [1:0] dlg_code_t;
    typedef logic [3:0] dlg_gain_t;
endpackage

// *** src/dlg_gain_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dlg_gain_if;
    import dlg_pkg::*;
    dlg_code_t foc_pre;
    logic foc_post;
    dlg_code_t ki_pre;
    logic ki_post;
    dlg_code_t kp_pre;
    logic kp_post;
    logic post_active;
    dlg_gain_t foc_gain;
    dlg_gain_t ki_gain;
    dlg_gain_t kp_gain;
    modport ctrl (output foc_pre, foc_post, ki_pre, ki_post, kp_pre, kp_post, post_active,
                  input foc_gain, ki_gain, kp_gain);
    modport sel (input foc_pre, foc_post, ki_pre, ki_post, kp_pre, kp_post, post_active,
                 output foc_gain, ki_gain, kp_gain);
endinterface
`default_nettype wire

// *** src/dlg_gain_sel.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dlg_params.svh"
module dlg_gain_sel
    import dlg_pkg::*;
(
    dlg_gain_if.sel g
);
    // code n maps to (n+1) times base, i.e. 2*(n+1) half-units
    function automatic dlg_gain_t pre_gain(input dlg_code_t c);
        dlg_gain_t n;
        n = {2'b00, c} + 4'h1;
        pre_gain = {n[2:0], 1'b0};
    endfunction

    // pre/post selection for all three loop gains
    always_comb begin
        g.foc_gain = pre_gain(g.foc_pre);
        g.ki_gain = pre_gain(g.ki_pre);
        g.kp_gain = pre_gain(g.kp_pre);
        if (g.post_active) begin
            if (g.foc_post) begin
                g.foc_gain = `DLG_GAIN_HALF;
            end
            if (g.ki_post) begin
                g.ki_gain = `DLG_GAIN_HALF;
            end
            if (g.kp_post) begin
                g.kp_gain = `DLG_GAIN_ONE;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/dlg_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlg_checker (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire logic reg_wr_in,
    input wire logic rx_start_in,
    input wire logic carrier_sense_in,
    input wire logic sync_detect_in,
    input wire logic freq_loop_freeze_out,
    input wire logic clkrec_loop_freeze_out,
    input wire logic post_sync_out,
    input wire logic [3:0] freq_gain_out,
    input wire logic [3:0] clkrec_proportional_gain_out,
    input wire logic freq_comp_enable_out,
    input wire logic [1:0] freq_offset_saturation_out
);
    // one clock domain, one reset
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_cs; carrier_sense_in |-> !freq_loop_freeze_out; endproperty
    a_cs: assert property (p_cs) else $error("freeze with carrier");
    property p_hold;
        clk_en_in && !reg_wr_in && !freq_loop_freeze_out && !rx_start_in |=> !freq_loop_freeze_out;
    endproperty
    a_hold: assert property (p_hold) else $error("freeze came back");
    property p_both; clkrec_loop_freeze_out == freq_loop_freeze_out; endproperty
    a_both: assert property (p_both) else $error("loops frozen apart");
    property p_en; freq_comp_enable_out == (freq_offset_saturation_out != 2'b00); endproperty
    a_en: assert property (p_en) else $error("enable vs limit");
    property p_rise; $rose(post_sync_out) |-> sync_detect_in; endproperty
    a_rise: assert property (p_rise) else $error("post without sync");
    property p_clr; clk_en_in && rx_start_in |=> !post_sync_out || sync_detect_in; endproperty
    a_clr: assert property (p_clr) else $error("post kept over start");
    property p_pre; !post_sync_out |-> freq_gain_out inside {4'h2, 4'h4, 4'h6, 4'h8}; endproperty
    a_pre: assert property (p_pre) else $error("bad presync gain");
    property p_kp; !post_sync_out |-> clkrec_proportional_gain_out inside {4'h2, 4'h4, 4'h6, 4'h8}; endproperty
    a_kp: assert property (p_kp) else $error("bad presync kp");
endmodule
bind dlg_top dlg_checker chk (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .reg_wr_in(reg_wr_in),
    .rx_start_in(rx_start_in),
    .carrier_sense_in(carrier_sense_in),
    .sync_detect_in(sync_detect_in),
    .freq_loop_freeze_out(freq_loop_freeze_out),
    .clkrec_loop_freeze_out(clkrec_loop_freeze_out),
    .post_sync_out(post_sync_out),
    .freq_gain_out(freq_gain_out),
    .clkrec_proportional_gain_out(clkrec_proportional_gain_out),
    .freq_comp_enable_out(freq_comp_enable_out),
    .freq_offset_saturation_out(freq_offset_saturation_out)
);
`default_nettype wire

// *** bench/dlg_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dlg_host_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic [5:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out
);
    // idle port at time zero
    initial begin
        addr_out = 6'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    // one-cycle write, data scrambled after release
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #2;
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clk_in);
        #2;
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask
    // one-cycle read, data taken after the answering edge
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #2;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge clk_in);
        #2;
        rd_out = 1'b0;
        d = rdata_in;
    endtask
    // on-off keying setup: limit field zero
    task automatic ook_setup();
        wr(6'h19, 8'h34);
    endtask
endmodule
`default_nettype wire

// *** bench/demod_loop_gain_config_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module demod_loop_gain_config_tb;
    import dlg_pkg::*;
    logic clk, clk_en, rst_n, rx_start, cs, sync, wr, rd, fz_f, fz_c, post, en;
    logic [5:0] addr;
    logic [7:0] wdata, rdata, v;
    dlg_gain_t g_f, g_i, g_p;
    dlg_code_t sat, rsat;
    int err_total = 0;
    int compares = 0;
    dlg_top dut (.sys_clk_in(clk), .rst_n_in(rst_n), .clk_en_in(clk_en), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .rx_start_in(rx_start),
        .carrier_sense_in(cs), .sync_detect_in(sync), .freq_loop_freeze_out(fz_f),
        .clkrec_loop_freeze_out(fz_c), .post_sync_out(post), .freq_gain_out(g_f),
        .clkrec_integral_gain_out(g_i), .clkrec_proportional_gain_out(g_p),
        .freq_offset_saturation_out(sat), .freq_comp_enable_out(en), .clkrec_rate_saturation_out(rsat));
    dlg_host_model host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
        .wdata_out(wdata));
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        #2;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard, run needs far fewer cycles
    initial begin
        #100000;
        err_total++;
        print_verdict();
    end
    initial begin
        {clk_en, rst_n, rx_start, cs, sync} = 5'h10;
        repeat (20) @(posedge clk);
        #2 rst_n = 1'b1;
        host.rd(6'h19, v);
        check("foc reset", v, 8'h36);
        host.rd(6'h1a, v);
        check("bs reset", v, 8'h6c);
        host.wr(6'h19, 8'hff);
        host.rd(6'h19, v);
        check("unused", v, 8'h3f);
        for (int c = 0; c < 4; c++) begin
            host.wr(6'h19, {3'h1, c[1:0], 1'b0, c[1:0]});
            host.wr(6'h1a, {c[1:0], c[1:0], 2'h0, c[1:0]});
            check("rate sat", rsat, 8'(c));
            check("fgain", g_f, 8'(2 * c + 2));
            check("ki", g_i, 8'(2 * c + 2));
            check("kp", g_p, 8'(2 * c + 2));
            check("limit", {en, sat}, {c != 0, c[1:0]});
        end
        host.wr(6'h19, 8'h3e);
        host.wr(6'h1a, 8'h2c);
        step();
        rx_start = 1'b1;
        step();
        rx_start = 1'b0;
        check("freeze", {fz_f, fz_c}, 8'h03);
        cs = 1'b1;
        #1 check("unfreeze", fz_f, 8'h00);
        step();
        {cs, sync} = 2'b01;
        #1 check("sticky", fz_c, 8'h00);
        check("post gains", {post, g_f, g_i, g_p}, {1'b1, 4'h1, 4'h1, 4'h2});
        step();
        {sync, rx_start} = 2'b01;
        step();
        rx_start = 1'b0;
        check("new try", {post, g_f}, 8'h08);
        host.ook_setup();
        check("comp off", en, 8'h00);
        host.wr(6'h19, 8'h30);
        host.wr(6'h1a, 8'h21);
        sync = 1'b1;
        #1 check("keep pre", {post, g_f, g_i, g_p}, {1'b1, 4'h6, 4'h2, 4'h6});
        step();
        sync = 1'b0;
        check("post stays", {post, g_f, rsat}, {1'b1, 4'h6, 2'h1});
        clk_en = 1'b0;
        host.wr(6'h19, 8'h00);
        clk_en = 1'b1;
        host.rd(6'h19, v);
        check("frozen", {v, g_f}, {8'h30, 4'h6});
        print_verdict();
    end
endmodule
`default_nettype wire
